// File: hdl/cmw_master_wrap.v
/*
  core-to-system-bus master wrapper: bus ownership machine, data routing,
  output drive control, vector test unit and control input multiplexer.
  assumes the core sits outside on the same clock; bus inputs come from
  another timing domain and are synchronised here.
*/
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "cmw_defs.vh"

module cmw_master_wrap #(
  parameter                      ENDIAN_BIG = 0,
  parameter                      IRQ_SYNC   = 1
) (
  clk,
  rst,
  ce,
  bus_reset_n,
  grant,
  wait_in,
  last_in,
  error_in,
  dsel,
  bd_in,
  bd_out,
  bd_oe,
  ba_out,
  ba_oe,
  btran_out,
  btran_oe,
  bwrite_out,
  bsize_out,
  bprot_out,
  blok_out,
  ctl_oe,
  areq,
  resp_out,
  resp_oe,
  sys_fast_irq_n,
  sys_irq_n,
  debug_channel_rx_status,
  debug_channel_tx_status,
  core_addr,
  core_dout,
  core_din,
  mem_request_n,
  burst_continue_flag,
  access_width_out,
  write_not_read,
  fetch_flag_n,
  user_access_n,
  core_lock,
  core_status,
  core_comm_rx,
  core_comm_tx,
  core_reset_n,
  core_stall_n,
  core_abort,
  fast_irq_n,
  irq_req_n,
  addr_drive_en,
  addr_latch_en,
  addr_pipe_en,
  endian_cfg,
  byte_capture_en,
  bus_split_sel,
  copro_missing,
  copro_stall,
  data_drive_en,
  debug_allow,
  break_in,
  debug_request_in,
  debug_ext_in,
  irq_synchronous_cfg,
  core_bus_enable_n,
  test_drive_en,
  scan_serial_return
);
  input  wire        clk;
  input  wire        rst;
  input  wire        ce;
  input  wire        bus_reset_n;
  input  wire        grant;
  input  wire        wait_in;
  input  wire        last_in;
  input  wire        error_in;
  input  wire        dsel;
  input  wire [31:0] bd_in;
  output reg  [31:0] bd_out;
  output wire        bd_oe;
  output reg  [31:0] ba_out;
  output wire        ba_oe;
  output reg  [1:0]  btran_out;
  output wire        btran_oe;
  output reg         bwrite_out;
  output reg  [1:0]  bsize_out;
  output reg  [1:0]  bprot_out;
  output reg         blok_out;
  output wire        ctl_oe;
  output wire        areq;
  output wire [2:0]  resp_out;
  output wire        resp_oe;
  input  wire        sys_fast_irq_n;
  input  wire        sys_irq_n;
  output wire        debug_channel_rx_status;
  output wire        debug_channel_tx_status;
  input  wire [31:0] core_addr;
  input  wire [31:0] core_dout;
  output reg  [31:0] core_din;
  input  wire        mem_request_n;
  input  wire        burst_continue_flag;
  input  wire [1:0]  access_width_out;
  input  wire        write_not_read;
  input  wire        fetch_flag_n;
  input  wire        user_access_n;
  input  wire        core_lock;
  input  wire [9:0]  core_status;
  input  wire        core_comm_rx;
  input  wire        core_comm_tx;
  output wire        core_reset_n;
  output wire        core_stall_n;
  output wire        core_abort;
  output wire        fast_irq_n;
  output wire        irq_req_n;
  output wire        addr_drive_en;
  output wire        addr_latch_en;
  output wire        addr_pipe_en;
  output wire        endian_cfg;
  output wire [3:0]  byte_capture_en;
  output wire        bus_split_sel;
  output wire        copro_missing;
  output wire        copro_stall;
  output wire        data_drive_en;
  output wire        debug_allow;
  output wire        break_in;
  output wire        debug_request_in;
  output wire [1:0]  debug_ext_in;
  output wire        irq_synchronous_cfg;
  output wire        core_bus_enable_n;
  output wire        test_drive_en;
  output wire        scan_serial_return;

  // two-flop synchronisers for the bus-side inputs
  reg [5:0]  sync1_r;
  reg [5:0]  sync2_r;
  reg [31:0] bd1_r;
  reg [31:0] bd2_r;
  wire       g_s    = sync2_r[0];
  wire       w_s    = sync2_r[1];
  wire       l_s    = sync2_r[2];
  wire       e_s    = sync2_r[3];
  wire       dsel_s = sync2_r[4];
  wire       brst_s = sync2_r[5];

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      bd1_r   <= 32'h00000000;
      bd2_r   <= 32'h00000000;
    end
    else if (ce)
    begin
      sync1_r <= {bus_reset_n, dsel, error_in, last_in, wait_in, grant};
      sync2_r <= sync1_r;
      bd1_r   <= bd_in;
      bd2_r   <= bd1_r;
    end
  end

  // ownership machine
  reg  [2:0] own_r;
  reg  [2:0] own_nxt;
  reg        err_r;
  reg  [2:0] tst_r;
  reg  [2:0] tst_nxt;
  reg  [27:0] treg_r;
  wire       test_on = (tst_r != `CMW_TS_INACTIVE);
  wire       want    = ~mem_request_n;
  wire       retract = w_s & l_s & e_s;

  always @*
  begin
    own_nxt = own_r;
    case (own_r)
      `CMW_OS_IDLE,
      `CMW_OS_BUSIDLE:
        if (g_s)
          own_nxt = want ? `CMW_OS_ACTIVE : `CMW_OS_BUSIDLE;
        else
          own_nxt = want ? `CMW_OS_HOLD : `CMW_OS_IDLE;
      `CMW_OS_HOLD:
        if (g_s)
          own_nxt = `CMW_OS_HANDOVER;
      `CMW_OS_HANDOVER:
        own_nxt = `CMW_OS_ACTIVE;
      `CMW_OS_ACTIVE:
        if (retract)
          own_nxt = `CMW_OS_RETRACT;
        else if (!w_s && !g_s)
          own_nxt = want ? `CMW_OS_HOLD : `CMW_OS_IDLE;
        else if (!w_s && !want)
          own_nxt = `CMW_OS_BUSIDLE;
      `CMW_OS_RETRACT:
        own_nxt = g_s ? `CMW_OS_HANDOVER : `CMW_OS_HOLD;
      default:
        own_nxt = `CMW_OS_IDLE;
    endcase
  end

  wire owned = (own_r == `CMW_OS_BUSIDLE) || (own_r == `CMW_OS_HANDOVER) ||
               (own_r == `CMW_OS_ACTIVE) || (own_r == `CMW_OS_RETRACT);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      own_r <= `CMW_OS_IDLE;
      err_r <= 1'b0;
    end
    else if (ce)
    begin
      own_r <= test_on ? `CMW_OS_IDLE : own_nxt;
      err_r <= e_s;
    end
  end

  // stall in hold, handover and retract, or in active while the slave waits
  wire norm_stall_n = ((own_r == `CMW_OS_ACTIVE) && !w_s) ||
                      (own_r == `CMW_OS_IDLE) || (own_r == `CMW_OS_BUSIDLE);

  // registered bus outputs; transfer type forced during handover pairs
  reg [1:0] tran_nxt;
  always @*
  begin
    tran_nxt = {~mem_request_n, burst_continue_flag};
    if (mem_request_n)
      tran_nxt = `CMW_TRAN_ADDR;
    if (own_nxt == `CMW_OS_HOLD || own_nxt == `CMW_OS_RETRACT)
      tran_nxt = `CMW_TRAN_ADDR;
    else if (own_nxt == `CMW_OS_HANDOVER)
      tran_nxt = `CMW_TRAN_SEQ;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ba_out     <= 32'h00000000;
      btran_out  <= `CMW_TRAN_ADDR;
      bwrite_out <= 1'b0;
      bsize_out  <= 2'h0;
      bprot_out  <= 2'h0;
      blok_out   <= 1'b0;
    end
    else if (ce)
    begin
      ba_out     <= core_addr;
      btran_out  <= tran_nxt;
      bwrite_out <= write_not_read;
      bsize_out  <= access_width_out;
      bprot_out  <= {user_access_n, fetch_flag_n};
      blok_out   <= core_lock;
    end
  end

  assign ba_oe    = owned & ~test_on;
  assign ctl_oe   = owned & ~test_on;
  assign btran_oe = g_s & ~test_on;
  assign areq     = 1'b1;

  // test sequencer: dsel steps through vectors
  reg  [31:0] dout_r;
  wire [31:0] status_word = {core_status, `CMW_STAT_PAD};

  always @*
  begin
    tst_nxt = tst_r;
    case (tst_r)
      `CMW_TS_INACTIVE:
        if (dsel_s)
          tst_nxt = `CMW_TS_CTRL_IN;
      `CMW_TS_CTRL_IN:
        if (dsel_s)
          tst_nxt = write_not_read ? `CMW_TS_DATA_OUT : `CMW_TS_DATA_IN;
      `CMW_TS_DATA_IN,
      `CMW_TS_DATA_OUT:
        if (dsel_s)
          tst_nxt = `CMW_TS_STAT_OUT;
      `CMW_TS_STAT_OUT:
        if (dsel_s)
          tst_nxt = `CMW_TS_ADDR_OUT;
      `CMW_TS_ADDR_OUT:
        if (dsel_s)
          tst_nxt = `CMW_TS_TURN;
      `CMW_TS_TURN:
        if (dsel_s)
          tst_nxt = `CMW_TS_CTRL_IN;
        else
          tst_nxt = `CMW_TS_INACTIVE;
      default:
        tst_nxt = `CMW_TS_INACTIVE;
    endcase
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tst_r  <= `CMW_TS_INACTIVE;
      treg_r <= 28'h0000000;
    end
    else if (ce)
    begin
      tst_r <= tst_nxt;
      if (tst_r == `CMW_TS_CTRL_IN && dsel_s)
        treg_r <= bd2_r[`CMW_TR_WIDTH-1:0];
    end
  end

  wire core_clocked = (tst_r == `CMW_TS_DATA_IN) || (tst_r == `CMW_TS_DATA_OUT);

  // read data in; write data, or the status and address vectors in test, out
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      core_din <= 32'h00000000;
      bd_out   <= 32'h00000000;
    end
    else if (ce)
    begin
      core_din <= bd2_r;
      // select on the next test state so the word stands in the state that enables it
      case (tst_nxt)
        `CMW_TS_STAT_OUT:
          bd_out <= status_word;
        `CMW_TS_ADDR_OUT:
          bd_out <= core_addr;
        default:
          bd_out <= core_dout;
      endcase
    end
  end

  assign bd_oe = test_on ? ((tst_r == `CMW_TS_DATA_OUT) || (tst_r == `CMW_TS_STAT_OUT) ||
                            (tst_r == `CMW_TS_ADDR_OUT))
                         : ((own_r == `CMW_OS_ACTIVE) & bwrite_out);

  // fixed zero-wait, no-error reply when selected for test
  assign resp_out = 3'h0;
  assign resp_oe  = test_on & dsel_s;

  assign core_reset_n       = test_on ? treg_r[`CMW_TR_RESET] : brst_s;
  assign core_stall_n       = test_on ? (treg_r[`CMW_TR_WAIT] & core_clocked) : norm_stall_n;
  assign core_abort         = test_on ? treg_r[`CMW_TR_ABORT] : err_r;
  assign fast_irq_n         = test_on ? treg_r[`CMW_TR_FIQ] : sys_fast_irq_n;
  assign irq_req_n          = test_on ? treg_r[`CMW_TR_IRQ] : sys_irq_n;
  assign addr_drive_en      = test_on ? treg_r[`CMW_TR_ABE] : 1'b1;
  assign addr_latch_en      = test_on ? treg_r[`CMW_TR_ALE] : 1'b1;
  assign addr_pipe_en       = test_on ? treg_r[`CMW_TR_APE] : 1'b1;
  assign endian_cfg         = test_on ? treg_r[`CMW_TR_ENDIAN] : (ENDIAN_BIG != 0);
  assign byte_capture_en    = test_on ? (treg_r[`CMW_TR_BL_HI:`CMW_TR_BL_LO] & {4{core_clocked}}) : 4'hf;
  assign bus_split_sel      = 1'b0;
  assign copro_missing      = test_on ? treg_r[`CMW_TR_CPA] : 1'b1;
  assign copro_stall        = test_on ? treg_r[`CMW_TR_CPB] : 1'b1;
  assign data_drive_en      = test_on ? (treg_r[`CMW_TR_DBE] & core_clocked) : 1'b1;
  assign debug_allow        = test_on ? treg_r[`CMW_TR_DEBUG_ALLOW] : 1'b1;
  assign break_in           = test_on ? treg_r[`CMW_TR_BRK] : 1'b0;
  assign debug_request_in   = test_on ? treg_r[`CMW_TR_DEBUG_REQUEST_IN] : 1'b0;
  assign debug_ext_in       = test_on ? {treg_r[`CMW_TR_EXT1], treg_r[`CMW_TR_EXT0]} : 2'h0;
  assign irq_synchronous_cfg = test_on ? treg_r[`CMW_TR_IRQ_SYNCHRONOUS_CFG] : (IRQ_SYNC != 0);
  assign core_bus_enable_n  = 1'b0;
  assign test_drive_en      = test_on ? treg_r[`CMW_TR_TBE] : 1'b1;
  assign scan_serial_return = test_on ? treg_r[`CMW_TR_SCAN] : 1'b0;
  assign debug_channel_rx_status = core_comm_rx;
  assign debug_channel_tx_status = core_comm_tx;
endmodule

// File: hdl/cmw_defs.vh
/*
  constants for the core-to-system-bus master wrapper: transfer codes,
  ownership and test states, test register field positions.
  assumes plain verilog-2005 inclusion by bare name.
*/
`ifndef CMW_DEFS_VH
`define CMW_DEFS_VH

// bus transfer type codes
`define CMW_TRAN_ADDR      2'h0
`define CMW_TRAN_NSEQ      2'h2
`define CMW_TRAN_SEQ       2'h3

// ownership states
`define CMW_OS_IDLE        3'h0
`define CMW_OS_BUSIDLE     3'h1
`define CMW_OS_HOLD        3'h2
`define CMW_OS_HANDOVER    3'h3
`define CMW_OS_ACTIVE      3'h4
`define CMW_OS_RETRACT     3'h5

// test states
`define CMW_TS_INACTIVE    3'h0
`define CMW_TS_CTRL_IN     3'h1
`define CMW_TS_DATA_IN     3'h2
`define CMW_TS_DATA_OUT    3'h3
`define CMW_TS_STAT_OUT    3'h4
`define CMW_TS_ADDR_OUT    3'h5
`define CMW_TS_TURN        3'h6

// test register layout
`define CMW_TR_WIDTH       28
`define CMW_TR_SCAN        27
`define CMW_TR_TBE         26
`define CMW_TR_APE         25
`define CMW_TR_BL_HI       24
`define CMW_TR_BL_LO       21
`define CMW_TR_EXT1        16
`define CMW_TR_EXT0        15
`define CMW_TR_DEBUG_REQUEST_IN       14
`define CMW_TR_BRK         13
`define CMW_TR_DEBUG_ALLOW       12
`define CMW_TR_IRQ_SYNCHRONOUS_CFG       11
`define CMW_TR_ENDIAN      10
`define CMW_TR_CPA         9
`define CMW_TR_CPB         8
`define CMW_TR_ABE         7
`define CMW_TR_ALE         6
`define CMW_TR_DBE         5
`define CMW_TR_FIQ         4
`define CMW_TR_IRQ         3
`define CMW_TR_ABORT       2
`define CMW_TR_WAIT        1
`define CMW_TR_RESET       0

// default tie-offs
`define CMW_ENDIAN_DEF     1'b0
`define CMW_IRQ_SYNCHRONOUS_CFG_DEF      1'b1
`define CMW_STAT_PAD       22'h000000

`endif

// File: test/cmw_master_wrap_props.sv
/*
  checker on the top ports of the master wrapper.
  assumes one clock domain and a slave that never retracts.
*/
`timescale 1ns/100ps
module cmw_master_wrap_props #(
  parameter ENDIAN_BIG = 0,
  parameter IRQ_SYNC   = 1
) (
  input wire logic        clk, rst, ce, bus_reset_n, grant, wait_in, error_in, dsel, core_lock,
  input wire logic        mem_request_n, burst_continue_flag, write_not_read, fetch_flag_n, user_access_n,
  input wire logic        sys_fast_irq_n, sys_irq_n, fast_irq_n, irq_req_n, core_comm_rx, core_comm_tx,
  input wire logic        debug_channel_rx_status, debug_channel_tx_status, core_reset_n, core_stall_n,
  input wire logic        ba_oe, bd_oe, btran_oe, ctl_oe, bwrite_out, blok_out,
  input wire logic        addr_drive_en, addr_latch_en, addr_pipe_en, bus_split_sel, copro_missing,
  input wire logic        copro_stall, data_drive_en, debug_allow, break_in, debug_request_in,
  input wire logic        core_bus_enable_n, test_drive_en, scan_serial_return, endian_cfg, irq_synchronous_cfg,
  input wire logic [1:0]  access_width_out, btran_out, bsize_out, bprot_out, debug_ext_in,
  input wire logic [3:0]  byte_capture_en,
  input wire logic [31:0] core_addr, bd_in, ba_out, core_din
);
  logic       tst_r;
  logic [1:0] age_r;
  logic [2:0] run_r;
  logic [2:0] run_nxt;

  // normal mode is only certain until the bus first selects the core for test
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tst_r <= 1'b0;
      age_r <= 2'h0;
      run_r <= 3'h0;
    end
    else
    begin
      tst_r <= tst_r | dsel;
      age_r <= (age_r == 2'h3) ? age_r : age_r + 2'h1;
      run_r <= run_nxt;
    end
  end
  // granted cycles with a clean response, so no handover or retract is near
  assign run_nxt = !(ce && grant && !wait_in && !error_in) ? 3'h0 : (run_r == 3'h7) ? run_r : run_r + 3'h1;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_ties;
    !tst_r |-> addr_drive_en && addr_latch_en && addr_pipe_en && byte_capture_en == 4'hf && !bus_split_sel
      && copro_missing && copro_stall && data_drive_en && !core_bus_enable_n && test_drive_en && !scan_serial_return;
  endproperty
  a_ties: assert property (p_ties) else $error("core tie-off wrong");
  property p_cfg;
    !tst_r |-> debug_allow && !break_in && !debug_request_in && debug_ext_in == 2'h0
      && endian_cfg == (ENDIAN_BIG != 0) && irq_synchronous_cfg == (IRQ_SYNC != 0);
  endproperty
  a_cfg: assert property (p_cfg) else $error("debug or config default wrong");
  property p_pass;
    !tst_r |-> fast_irq_n == sys_fast_irq_n && irq_req_n == sys_irq_n
      && debug_channel_rx_status == core_comm_rx && debug_channel_tx_status == core_comm_tx;
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through wrong");
  property p_reset;
    !tst_r && ce ##1 ce |-> ##1 core_reset_n == $past(bus_reset_n, 2);
  endproperty
  a_reset: assert property (p_reset) else $error("core reset not following bus reset");
  property p_drv_off;
    (ce && !grant && !tst_r) [*4] |-> !ba_oe && !bd_oe && !btran_oe && !ctl_oe;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("drive while not granted");
  property p_stall;
    age_r == 2'h3 && !tst_r && $past(ce) && $past(ce, 2) && !$past(mem_request_n) && $past(wait_in, 2)
      |-> !core_stall_n;
  endproperty
  a_stall: assert property (p_stall) else $error("core ran through a bus wait");
  property p_tran;
    run_r == 3'h7 && !tst_r |-> btran_out == {~$past(mem_request_n), $past(burst_continue_flag)}
      && ba_out == $past(core_addr) && bwrite_out == $past(write_not_read) && bsize_out == $past(access_width_out)
      && bprot_out == {$past(user_access_n), $past(fetch_flag_n)} && blok_out == $past(core_lock);
  endproperty
  a_tran: assert property (p_tran) else $error("bus control not from core");
  property p_din;
    !tst_r && ce ##1 ce ##1 ce |-> ##1 core_din == $past(bd_in, 3);
  endproperty
  a_din: assert property (p_din) else $error("core data in not from bus");

  c_grant: cover property ($rose(ba_oe));
  c_wait: cover property (ba_oe && !core_stall_n);
  c_test: cover property (tst_r && grant);
endmodule

// File: test/cmw_bus_partner.sv
/*
  far side: arbiter grant, slave wait and error answers, read data, test select.
  assumes the bench changes its knobs just after a rising edge.
*/
`timescale 1ns/100ps
module cmw_bus_partner (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        gnt_on,
  input  wire logic [1:0]  waits,
  input  wire logic        err_on,
  input  wire logic        sel_on,
  input  wire logic [31:0] rd_data,
  input  wire logic [31:0] bd_out,
  input  wire logic        bd_oe,
  output logic             grant,
  output logic             wait_in,
  output logic             last_in,
  output logic             error_in,
  output logic             dsel,
  output logic [31:0]      bd_in
);
  logic [1:0]  wcnt_r;
  logic [31:0] prev_r;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      grant <= 1'b0;
      dsel <= 1'b0;
      wcnt_r <= 2'h0;
      prev_r <= 32'h0;
    end
    else
    begin
      grant <= gnt_on;
      dsel <= sel_on;
      wcnt_r <= (!grant || wcnt_r >= waits) ? 2'h0 : wcnt_r + 2'h1;
      prev_r <= bd_in;
    end
  end
  // a released bus keeps no value: it flips every cycle
  assign bd_in = bd_oe ? bd_out : grant ? rd_data : ~prev_r;
  assign wait_in = grant && (wcnt_r < waits);
  assign error_in = grant && err_on && !wait_in;
  assign last_in = 1'b0;
endmodule

// File: test/cmw_master_wrap_tb.sv
/*
  bench for the master wrapper: core side driven here, bus side by the partner.
  assumes 10 MHz clock; the checker is bound below.
*/
`timescale 1ns/100ps
module cmw_master_wrap_tb;
  logic        clk, rst, ce, bus_reset_n, sys_fast_irq_n, sys_irq_n, core_comm_rx, core_comm_tx;
  logic        mem_request_n, burst_continue_flag, write_not_read, fetch_flag_n, user_access_n, core_lock;
  logic        gnt_on, err_on, sel_on, grant, wait_in, last_in, error_in, dsel, bd_oe, ba_oe, btran_oe;
  logic        bwrite_out, blok_out, ctl_oe, areq, resp_oe, debug_channel_rx_status, debug_channel_tx_status;
  logic        core_reset_n, core_stall_n, core_abort, fast_irq_n, irq_req_n, addr_drive_en, addr_latch_en;
  logic        addr_pipe_en, endian_cfg, bus_split_sel, copro_missing, copro_stall, data_drive_en, debug_allow;
  logic        break_in, debug_request_in, irq_synchronous_cfg, core_bus_enable_n, test_drive_en;
  logic        scan_serial_return;
  logic [1:0]  waits, access_width_out, btran_out, bsize_out, bprot_out, debug_ext_in;
  logic [2:0]  resp_out;
  logic [3:0]  byte_capture_en;
  logic [9:0]  core_status;
  logic [31:0] core_addr, core_dout, rd_data, bd_in, bd_out, ba_out, core_din;
  int          mismatches;
  int          compares;
  int          n;

  cmw_master_wrap cmw_master_wrap_inst (.*);
  cmw_bus_partner cmw_bus_partner_inst (.*);

  always #50 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wt(input int cycles);
    repeat (cycles) @(posedge clk);
  endtask

  task automatic end_sim;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    {clk, sys_fast_irq_n, sys_irq_n, core_comm_rx, core_comm_tx, burst_continue_flag, write_not_read} = '0;
    {core_lock, gnt_on, err_on, sel_on, waits, access_width_out, core_status, core_addr, core_dout, rd_data} = '0;
    {rst, ce, bus_reset_n, mem_request_n, fetch_flag_n, user_access_n} = '1;
    mismatches = 0;
    compares = 0;
    wt(8);
    rst <= 1'b0;
    wt(4);
    @(negedge clk);
    chk({addr_drive_en, addr_latch_en, addr_pipe_en, byte_capture_en}, 32'h7f, "enables");
    chk({bus_split_sel, core_bus_enable_n, scan_serial_return, break_in, debug_request_in, debug_ext_in}, 32'h0, "lows");
    chk({copro_missing, copro_stall, data_drive_en, test_drive_en, debug_allow}, 32'h1f, "highs");
    chk({endian_cfg, irq_synchronous_cfg}, 32'h1, "config");
    wt(1);
    bus_reset_n <= 1'b0;
    wt(3);
    @(negedge clk);
    chk(core_reset_n, 32'h0, "core reset low");
    wt(1);
    bus_reset_n <= 1'b1;
    wt(3);
    @(negedge clk);
    chk(core_reset_n, 32'h1, "core reset high");
    $display("test ties done");
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      {sys_fast_irq_n, sys_irq_n, core_comm_rx, core_comm_tx} <= i[3:0];
      @(negedge clk);
      chk({fast_irq_n, irq_req_n}, i[3:2], "irq pass");
      chk({debug_channel_rx_status, debug_channel_tx_status}, i[1:0], "status pass");
    end
    $display("test pass done");
    wt(1);
    {mem_request_n, write_not_read, core_lock, access_width_out} <= 5'h0e;
    core_addr <= 32'h0000_1000;
    core_dout <= 32'ha5a5_3c3c;
    wt(6);
    @(negedge clk);
    chk({core_stall_n, ba_oe, bd_oe, btran_oe}, 32'h0, "hold");
    wt(1);
    gnt_on <= 1'b1;
    for (int k = 0; k < 10 && ba_oe !== 1'b1; k++) @(negedge clk);
    chk(ba_oe, 32'h1, "granted drive");
    wt(3);
    @(negedge clk);
    chk({core_stall_n, btran_out, bd_oe}, 32'hd, "active write");
    chk(ba_out, 32'h0000_1000, "address");
    chk({bwrite_out, bsize_out, bprot_out, blok_out}, 32'h37, "attributes");
    chk(bd_out, 32'ha5a5_3c3c, "write data");
    wt(1);
    burst_continue_flag <= 1'b1;
    wt(2);
    @(negedge clk);
    chk(btran_out, 32'h3, "sequential");
    wt(1);
    {write_not_read, burst_continue_flag} <= 2'h0;
    rd_data <= 32'h1234_5678;
    wt(5);
    @(negedge clk);
    chk({bd_oe, bwrite_out}, 32'h0, "read released");
    chk(core_din, 32'h1234_5678, "read data");
    $display("test transfer done");
    wt(1);
    waits <= 2'h2;
    wt(4);
    n = 0;
    repeat (6)
    begin
      @(negedge clk);
      n += (core_stall_n === 1'b0);
    end
    chk(n, 32'h4, "wait stalls");
    wt(1);
    waits <= 2'h0;
    err_on <= 1'b1;
    wt(5);
    @(negedge clk);
    chk(core_abort, 32'h1, "fault set");
    wt(1);
    err_on <= 1'b0;
    wt(5);
    @(negedge clk);
    chk(core_abort, 32'h0, "fault clear");
    $display("test response done");
    wt(1);
    gnt_on <= 1'b0;
    wt(6);
    @(negedge clk);
    chk({ba_oe, bd_oe, btran_oe, ctl_oe, core_stall_n}, 32'h0, "grant lost");
    $display("test release done");
    wt(1);
    {mem_request_n, gnt_on, sel_on} <= 3'h7;
    core_status <= 10'h2a5;
    wt(7);
    @(negedge clk);
    chk({resp_oe, resp_out, ba_oe, btran_oe}, 32'h20, "test mode");
    chk(bd_out, 32'h0000_1000, "address vector");
    chk({core_reset_n, endian_cfg, copro_missing, addr_drive_en}, 32'h6, "test controls");
    wt(1);
    rst <= 1'b1;
    {gnt_on, sel_on} <= 2'h0;
    wt(2);
    rst <= 1'b0;
    wt(4);
    @(negedge clk);
    chk({resp_oe, copro_missing}, 32'h1, "after reset");
    $display("test vector done");
    end_sim;
  end

  // run needs about 105 cycles
  initial
  begin
    #200000;
    $display("watchdog expired");
    mismatches++;
    end_sim;
  end
endmodule

bind cmw_master_wrap cmw_master_wrap_props #(.ENDIAN_BIG(ENDIAN_BIG), .IRQ_SYNC(IRQ_SYNC)) cmw_master_wrap_props_inst (.*);
